// ---- logic/dpr_cfg.svh ----
// register offsets, reset values, writable masks and field positions of the
// demodulator/synthesizer control bank; definitions only.
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

// serial frame layout: read flag, 7-bit address, 16-bit data, msb first
`define DPR_ADDR_W 7
`define DPR_DATA_W 16
`define DPR_CMD_BITS 5'h08
`define DPR_FRAME_BITS 5'h18

// register offsets
`define DPR_OFS_BALUN 7'h30
`define DPR_OFS_MIXER 7'h31
`define DPR_OFS_BBMODE0 7'h32
`define DPR_OFS_DCNULL 7'h33
`define DPR_OFS_BBBIAS 7'h34
`define DPR_OFS_PFD2 7'h40
`define DPR_OFS_DITH1 7'h42
`define DPR_OFS_SEED 7'h43
`define DPR_OFS_DIVSM 7'h44
`define DPR_OFS_BANDCTL 7'h45
`define DPR_OFS_BANDRB 7'h46
`define DPR_OFS_OSCSET 7'h49

// reset values
`define DPR_RST_BALUN 16'h0000
`define DPR_RST_MIXER 16'h1101
`define DPR_RST_BBMODE0 16'h0900
`define DPR_RST_DCNULL 16'h0000
`define DPR_RST_BBBIAS 16'h0b00
`define DPR_RST_PFD2 16'h0010
`define DPR_RST_DITH1 16'h000e
`define DPR_RST_SEED 16'h0001
`define DPR_RST_DIVSM 16'h0000
`define DPR_RST_BANDCTL 16'h0000
`define DPR_RST_BANDRB 16'h0000
`define DPR_RST_OSCSET 16'h16bd

// writable bits (BANDRB: readback bits, not writable); all others read zero
`define DPR_MSK_BALUN 16'h00ee
`define DPR_MSK_MIXER 16'h1def
`define DPR_MSK_BBMODE0 16'hffff
`define DPR_MSK_DCNULL 16'hffff
`define DPR_MSK_BBBIAS 16'h0f00
`define DPR_MSK_PFD2 16'h007f
`define DPR_MSK_DITH1 16'h000f
`define DPR_MSK_SEED 16'hffff
`define DPR_MSK_DIVSM 16'h0001
`define DPR_MSK_BANDCTL 16'h00ff
`define DPR_MSK_BANDRB 16'h003f
`define DPR_MSK_OSCSET 16'h3fff

// field positions (lsb)
`define DPR_POS_BAL_COUT 5
`define DPR_POS_BAL_CIN 1
`define DPR_POS_MIX_BIAS 10
`define DPR_POS_RES_TRIM 5
`define DPR_POS_CAP_TRIM 0
`define DPR_POS_DC_I 8
`define DPR_POS_DC_Q 0
`define DPR_POS_BB_BIAS 10
`define DPR_POS_BW_MODE 8
`define DPR_POS_ABL_DLY 5
`define DPR_POS_CP_CTRL 2
`define DPR_POS_EDGE 0
`define DPR_POS_DITH_EN 3
`define DPR_POS_DITH_MAG 1
`define DPR_POS_DITH_VAL 0
`define DPR_POS_AUTOCAL_DIS 0
`define DPR_POS_BAND_SRC 7
`define DPR_POS_BAND 0
`define DPR_POS_SET1 9
`define DPR_POS_SET0 0

`endif

// ---- logic/dpr_pkg.sv ----
// types of the demodulator/synthesizer control bank
// assumes dpr_cfg.svh is compiled alongside
package dpr_pkg;

  typedef enum logic [1:0] {
    DPR_IDLE = 2'b00,
    DPR_CMD = 2'b01,
    DPR_WDATA = 2'b10,
    DPR_RDATA = 2'b11
  } dpr_phase_type;

  typedef struct packed {
    logic level_q;
  } dpr_edge_state_type;

  typedef struct packed {
    dpr_phase_type phase;
    logic [4:0] bit_cnt;
    logic [7:0] cmd;
    logic [15:0] shift;
    logic [6:0] addr;
    logic sdo;
    logic drive;
    logic [15:0] balun;
    logic [15:0] mixer;
    logic [15:0] bbmode0;
    logic [15:0] dcnull;
    logic [15:0] bbbias;
    logic [15:0] pfd2;
    logic [15:0] dith1;
    logic [15:0] seed;
    logic [15:0] divsm;
    logic [15:0] bandctl;
    logic [15:0] bandrb;
    logic [15:0] oscset;
  } dpr_regs_state_type;

endpackage : dpr_pkg

// ---- logic/dpr_edge_detect.sv ----
// edge detector for a level sampled on mclk
// assumes the level is already synchronous to mclk
`timescale 1ns/1ps
module dpr_edge_detect (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic level,
  output logic rise,
  output logic fall
);

  dpr_pkg::dpr_edge_state_type st_r;
  dpr_pkg::dpr_edge_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.level_q = level;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rise = ce & level & ~st_r.level_q;
  assign fall = ce & ~level & st_r.level_q;

endmodule : dpr_edge_detect

// ---- logic/dpr_regs.sv ----
// control and readback register bank of the demodulator and synthesizer,
// reached over the three-wire serial interface.
// assumes serial pins are synchronous to mclk and sclk is slower than mclk/2.
`timescale 1ns/1ps
`include "dpr_cfg.svh"

module dpr_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic serial_cs_n,
  input wire logic serial_sclk,
  input wire logic serial_sdio_in,
  output logic serial_sdio_out,
  output logic serial_sdio_oe_n,
  input wire logic [6:0] cal_band,
  output logic [6:0] osc_band_sel,
  output logic autocal_disable,
  output logic [2:0] balun_out_cap,
  output logic [2:0] balun_in_cap,
  output logic [2:0] demod_bias,
  output logic [3:0] linearizer_resistor_trim,
  output logic [3:0] linearizer_capacitor_trim,
  output logic [15:0] baseband_mode0_word,
  output logic inphase_dc_null_neg,
  output logic [6:0] inphase_dc_null_mag,
  output logic quadrature_dc_null_neg,
  output logic [6:0] quadrature_dc_null_mag,
  output logic [1:0] baseband_bias,
  output logic [1:0] baseband_gain_bw_mode,
  output logic [1:0] antibacklash_delay,
  output logic [2:0] charge_pump_control,
  output logic [1:0] detector_edge_select,
  output logic dither_enable,
  output logic [1:0] dither_magnitude,
  output logic dither_value,
  output logic [15:0] dither_seed_word,
  output logic osc_band_source,
  output logic [4:0] osc_setting_hi,
  output logic [8:0] osc_setting_lo
);

  dpr_pkg::dpr_regs_state_type st_r;
  dpr_pkg::dpr_regs_state_type st_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] cmd_full;
  logic [15:0] wdata_full;
  logic [6:0] band_mux;

  dpr_edge_detect u_sclk_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .level(serial_sclk),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );

  // register read decode; unmapped addresses read zero
  function automatic logic [15:0] read_word(
    input logic [6:0] a,
    input dpr_pkg::dpr_regs_state_type s
  );
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      `DPR_OFS_BALUN: w = s.balun;
      `DPR_OFS_MIXER: w = s.mixer;
      `DPR_OFS_BBMODE0: w = s.bbmode0;
      `DPR_OFS_DCNULL: w = s.dcnull;
      `DPR_OFS_BBBIAS: w = s.bbbias;
      `DPR_OFS_PFD2: w = s.pfd2;
      `DPR_OFS_DITH1: w = s.dith1;
      `DPR_OFS_SEED: w = s.seed;
      `DPR_OFS_DIVSM: w = s.divsm;
      `DPR_OFS_BANDCTL: w = s.bandctl;
      `DPR_OFS_BANDRB: w = s.bandrb;
      `DPR_OFS_OSCSET: w = s.oscset;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  assign cmd_full = {st_r.cmd[6:0], serial_sdio_in};
  assign wdata_full = {st_r.shift[14:0], serial_sdio_in};

  // band fed to the oscillator: host value when source bit set, else calibration
  assign band_mux = st_r.bandctl[`DPR_POS_BAND_SRC] ?
                    st_r.bandctl[`DPR_POS_BAND +: 7] : cal_band;

  always_comb begin
    st_nxt = st_r;
    // readback follows bits 5:0 of the band mux every cycle
    st_nxt.bandrb = {10'h000, band_mux[5:0]} & `DPR_MSK_BANDRB;
    if (serial_cs_n) begin
      st_nxt.phase = dpr_pkg::DPR_IDLE;
      st_nxt.bit_cnt = 5'h00;
      st_nxt.drive = 1'b0;
      st_nxt.sdo = 1'b0;
    end else begin
      case (st_r.phase)
        dpr_pkg::DPR_IDLE: begin
          st_nxt.phase = dpr_pkg::DPR_CMD;
          st_nxt.bit_cnt = 5'h00;
          st_nxt.cmd = 8'h00;
          if (sclk_rise) begin
            st_nxt.cmd = {7'h00, serial_sdio_in};
            st_nxt.bit_cnt = 5'h01;
          end
        end
        dpr_pkg::DPR_CMD: begin
          if (sclk_rise && st_r.bit_cnt < `DPR_FRAME_BITS) begin
            st_nxt.cmd = cmd_full;
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            if (st_r.bit_cnt == `DPR_CMD_BITS - 5'h01) begin
              st_nxt.addr = cmd_full[6:0];
              if (cmd_full[7]) begin
                st_nxt.phase = dpr_pkg::DPR_RDATA;
                st_nxt.shift = read_word(cmd_full[6:0], st_r);
              end else begin
                st_nxt.phase = dpr_pkg::DPR_WDATA;
                st_nxt.shift = 16'h0000;
              end
            end
          end
        end
        dpr_pkg::DPR_WDATA: begin
          if (sclk_rise && st_r.bit_cnt < `DPR_FRAME_BITS) begin
            st_nxt.shift = wdata_full;
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            if (st_r.bit_cnt == `DPR_FRAME_BITS - 5'h01) begin
              case (st_r.addr)
                `DPR_OFS_BALUN: st_nxt.balun = wdata_full & `DPR_MSK_BALUN;
                `DPR_OFS_MIXER: st_nxt.mixer = wdata_full & `DPR_MSK_MIXER;
                `DPR_OFS_BBMODE0: st_nxt.bbmode0 = wdata_full & `DPR_MSK_BBMODE0;
                `DPR_OFS_DCNULL: st_nxt.dcnull = wdata_full & `DPR_MSK_DCNULL;
                `DPR_OFS_BBBIAS: st_nxt.bbbias = wdata_full & `DPR_MSK_BBBIAS;
                `DPR_OFS_PFD2: st_nxt.pfd2 = wdata_full & `DPR_MSK_PFD2;
                `DPR_OFS_DITH1: st_nxt.dith1 = wdata_full & `DPR_MSK_DITH1;
                `DPR_OFS_SEED: st_nxt.seed = wdata_full & `DPR_MSK_SEED;
                `DPR_OFS_DIVSM: st_nxt.divsm = wdata_full & `DPR_MSK_DIVSM;
                `DPR_OFS_BANDCTL: st_nxt.bandctl = wdata_full & `DPR_MSK_BANDCTL;
                `DPR_OFS_OSCSET: st_nxt.oscset = wdata_full & `DPR_MSK_OSCSET;
                default: st_nxt.shift = wdata_full;
              endcase
            end
          end
        end
        dpr_pkg::DPR_RDATA: begin
          if (sclk_rise && st_r.bit_cnt < `DPR_FRAME_BITS) begin
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
          end
          // present next bit after each falling edge while the data phase lasts
          if (sclk_fall && st_r.bit_cnt < `DPR_FRAME_BITS) begin
            st_nxt.sdo = st_r.shift[15];
            st_nxt.shift = {st_r.shift[14:0], 1'b0};
            st_nxt.drive = 1'b1;
          end
          if (sclk_fall && st_r.bit_cnt == `DPR_FRAME_BITS) begin
            st_nxt.drive = 1'b0;
          end
        end
        default: begin
          st_nxt.phase = dpr_pkg::DPR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.phase <= dpr_pkg::DPR_IDLE;
      st_r.bit_cnt <= 5'h00;
      st_r.cmd <= 8'h00;
      st_r.shift <= 16'h0000;
      st_r.addr <= 7'h00;
      st_r.sdo <= 1'b0;
      st_r.drive <= 1'b0;
      st_r.balun <= `DPR_RST_BALUN;
      st_r.mixer <= `DPR_RST_MIXER;
      st_r.bbmode0 <= `DPR_RST_BBMODE0;
      st_r.dcnull <= `DPR_RST_DCNULL;
      st_r.bbbias <= `DPR_RST_BBBIAS;
      st_r.pfd2 <= `DPR_RST_PFD2;
      st_r.dith1 <= `DPR_RST_DITH1;
      st_r.seed <= `DPR_RST_SEED;
      st_r.divsm <= `DPR_RST_DIVSM;
      st_r.bandctl <= `DPR_RST_BANDCTL;
      st_r.bandrb <= `DPR_RST_BANDRB;
      st_r.oscset <= `DPR_RST_OSCSET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign serial_sdio_out = st_r.sdo;
  assign serial_sdio_oe_n = ~st_r.drive;
  assign osc_band_sel = band_mux;
  assign autocal_disable = st_r.divsm[`DPR_POS_AUTOCAL_DIS];
  assign balun_out_cap = st_r.balun[`DPR_POS_BAL_COUT +: 3];
  assign balun_in_cap = st_r.balun[`DPR_POS_BAL_CIN +: 3];
  assign demod_bias = st_r.mixer[`DPR_POS_MIX_BIAS +: 3];
  assign linearizer_resistor_trim = st_r.mixer[`DPR_POS_RES_TRIM +: 4];
  assign linearizer_capacitor_trim = st_r.mixer[`DPR_POS_CAP_TRIM +: 4];
  assign baseband_mode0_word = st_r.bbmode0;
  // sign and magnitude split; 0x80 and 0x00 both give zero current
  assign inphase_dc_null_neg = st_r.dcnull[`DPR_POS_DC_I + 7];
  assign inphase_dc_null_mag = st_r.dcnull[`DPR_POS_DC_I +: 7];
  assign quadrature_dc_null_neg = st_r.dcnull[`DPR_POS_DC_Q + 7];
  assign quadrature_dc_null_mag = st_r.dcnull[`DPR_POS_DC_Q +: 7];
  assign baseband_bias = st_r.bbbias[`DPR_POS_BB_BIAS +: 2];
  assign baseband_gain_bw_mode = st_r.bbbias[`DPR_POS_BW_MODE +: 2];
  assign antibacklash_delay = st_r.pfd2[`DPR_POS_ABL_DLY +: 2];
  assign charge_pump_control = st_r.pfd2[`DPR_POS_CP_CTRL +: 3];
  assign detector_edge_select = st_r.pfd2[`DPR_POS_EDGE +: 2];
  assign dither_enable = st_r.dith1[`DPR_POS_DITH_EN];
  assign dither_magnitude = st_r.dith1[`DPR_POS_DITH_MAG +: 2];
  assign dither_value = st_r.dith1[`DPR_POS_DITH_VAL];
  assign dither_seed_word = st_r.seed;
  assign osc_band_source = st_r.bandctl[`DPR_POS_BAND_SRC];
  assign osc_setting_hi = st_r.oscset[`DPR_POS_SET1 +: 5];
  assign osc_setting_lo = st_r.oscset[`DPR_POS_SET0 +: 9];

endmodule : dpr_regs

// ---- tb/dpr_regs_properties.sv ----
// port assertions for the demodulator/synthesizer control bank
// bound to dpr_regs from tb; one clock domain, async reset
`timescale 1ns/1ps
module dpr_regs_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serial_cs_n,
  input wire logic serial_sdio_oe_n,
  input wire logic [6:0] cal_band,
  input wire logic [6:0] osc_band_sel,
  input wire logic osc_band_source,
  input wire logic autocal_disable,
  input wire logic [2:0] demod_bias,
  input wire logic [3:0] linearizer_resistor_trim,
  input wire logic [3:0] linearizer_capacitor_trim,
  input wire logic inphase_dc_null_neg,
  input wire logic [6:0] inphase_dc_null_mag,
  input wire logic quadrature_dc_null_neg,
  input wire logic [6:0] quadrature_dc_null_mag,
  input wire logic [1:0] baseband_gain_bw_mode,
  input wire logic [2:0] charge_pump_control,
  input wire logic [1:0] detector_edge_select,
  input wire logic [4:0] osc_setting_hi,
  input wire logic [8:0] osc_setting_lo
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  band_cal_a: assert property (!osc_band_source |-> osc_band_sel == cal_band)
    else $error("band mux does not follow calibration input");
  band_hold_a: assert property (osc_band_source && serial_cs_n && $past(serial_cs_n)
    && $past(serial_cs_n, 2) |-> $stable(osc_band_sel)) else $error("host band moved");
  rst_mixer_a: assert property ($fell(sys_rst) |-> demod_bias == 3'h4
    && linearizer_resistor_trim == 4'h8 && linearizer_capacitor_trim == 4'h1)
    else $error("mixer fields wrong after reset");
  rst_pfd_a: assert property ($fell(sys_rst) |-> baseband_gain_bw_mode == 2'h3
    && charge_pump_control == 3'h4 && detector_edge_select == 2'h0)
    else $error("mode or pump fields wrong after reset");
  rst_band_a: assert property ($fell(sys_rst) |-> !autocal_disable && !osc_band_source
    && osc_setting_hi == 5'h0b && osc_setting_lo == 9'h0bd) else $error("band fields wrong after reset");
  rst_dc_a: assert property ($fell(sys_rst) |-> {inphase_dc_null_neg, inphase_dc_null_mag,
    quadrature_dc_null_neg, quadrature_dc_null_mag} == 16'h0000) else $error("dc null not zero");
  idle_hold_a: assert property (serial_cs_n && $past(serial_cs_n) |-> $stable({
    demod_bias, charge_pump_control, autocal_disable, inphase_dc_null_mag}))
    else $error("field moved while idle");
  oe_idle_a: assert property (serial_cs_n && $past(serial_cs_n) |-> serial_sdio_oe_n)
    else $error("data line driven while deselected");
endmodule : dpr_regs_properties

// ---- tb/dpr_sif_host.sv ----
// three-wire serial host model: 24-bit frames, msb first
// drives on mclk falling edges; sclk stands low between frames
`timescale 1ns/1ps
module dpr_serial_host (
  input wire logic mclk,
  input wire logic sdio,
  output logic cs_n,
  output logic sclk,
  output logic sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdo = 1'b0;
  end
  // n below 24 aborts the frame; h is the sclk half period in mclk cycles
  task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                       input int n, input int h, output logic [15:0] rdat);
    logic [23:0] w;
    w = {rd, a, wd};
    rdat = 16'h0000;
    cs_n = 1'b0;
    repeat (h) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      // released line during read data shows a changing pattern
      if (rd && i > 7) sdo = ~sdo;
      else sdo = w[23-i];
      repeat (h) @(negedge mclk);
      rdat = {rdat[14:0], sdio};
      sclk = 1'b1;
      repeat (h) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (h) @(negedge mclk);
    cs_n = 1'b1;
    sdo = ~sdo;
    repeat (2) @(negedge mclk);
  endtask : frame
endmodule : dpr_serial_host

// ---- tb/tb.sv ----
// self-checking bench for dpr_regs with a serial host model
// assumes dpr_cfg.svh on the include path
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] cal_band = 7'h00;
  logic cs_n, sclk, hsdo, sdo, oe_n, sdio_w, ineg, qneg, acd, bsrc;
  logic [6:0] band_sel, imag, qmag;
  logic [2:0] bias, cp;
  logic [3:0] rtrim, ctrim;
  logic [1:0] bwm, edg;
  logic [2:0] balo, bali;
  logic [15:0] bbw, seedw;
  logic [1:0] bbb, abl, dmag;
  logic den, dval;
  logic [4:0] seth;
  logic [8:0] setl;
  logic [15:0] rnd = 16'h003d;
  logic [15:0] shadow [13];
  logic [6:0] ofs [13] = '{7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h40, 7'h42, 7'h43, 7'h44,
    7'h45, 7'h46, 7'h49, 7'h50};
  logic [15:0] rst [13] = '{`DPR_RST_BALUN, `DPR_RST_MIXER, `DPR_RST_BBMODE0, `DPR_RST_DCNULL,
    `DPR_RST_BBBIAS, `DPR_RST_PFD2, `DPR_RST_DITH1, `DPR_RST_SEED, `DPR_RST_DIVSM,
    `DPR_RST_BANDCTL, `DPR_RST_BANDRB, `DPR_RST_OSCSET, 16'h0000};
  logic [15:0] msk [13] = '{`DPR_MSK_BALUN, `DPR_MSK_MIXER, `DPR_MSK_BBMODE0, `DPR_MSK_DCNULL,
    `DPR_MSK_BBBIAS, `DPR_MSK_PFD2, `DPR_MSK_DITH1, `DPR_MSK_SEED, `DPR_MSK_DIVSM,
    `DPR_MSK_BANDCTL, 16'h0000, `DPR_MSK_OSCSET, 16'h0000};
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #12.5 mclk = ~mclk;
  assign sdio_w = oe_n ? hsdo : sdo;

  dpr_serial_host host (.mclk(mclk), .sdio(sdio_w), .cs_n(cs_n), .sclk(sclk), .sdo(hsdo));

  dpr_regs dut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .serial_cs_n(cs_n),
    .serial_sclk(sclk), .serial_sdio_in(sdio_w), .serial_sdio_out(sdo), .serial_sdio_oe_n(oe_n),
    .cal_band(cal_band), .osc_band_sel(band_sel), .autocal_disable(acd), .balun_out_cap(balo),
    .balun_in_cap(bali), .demod_bias(bias), .linearizer_resistor_trim(rtrim),
    .linearizer_capacitor_trim(ctrim), .baseband_mode0_word(bbw), .inphase_dc_null_neg(ineg),
    .inphase_dc_null_mag(imag), .quadrature_dc_null_neg(qneg), .quadrature_dc_null_mag(qmag),
    .baseband_bias(bbb), .baseband_gain_bw_mode(bwm), .antibacklash_delay(abl),
    .charge_pump_control(cp), .detector_edge_select(edg), .dither_enable(den),
    .dither_magnitude(dmag), .dither_value(dval), .dither_seed_word(seedw),
    .osc_band_source(bsrc), .osc_setting_hi(seth), .osc_setting_lo(setl));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [15:0] band_exp();
    logic [6:0] b;
    b = shadow[9][7] ? shadow[9][6:0] : cal_band;
    return {10'h000, b[5:0]};
  endfunction : band_exp

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input int k, input logic [15:0] d);
    logic [15:0] r;
    rnd = lfsr_next(rnd);
    host.frame(1'b0, ofs[k], d, 24, 2 + rnd[0], r);
    if (k != 10) shadow[k] = d & msk[k];
  endtask : wr

  task automatic rd(input int k);
    logic [15:0] r;
    rnd = lfsr_next(rnd);
    host.frame(1'b1, ofs[k], 16'h0000, 24, 2 + rnd[0], r);
    check("readback", r, k == 10 ? band_exp() : shadow[k]);
  endtask : rd

  task automatic chk_ports();
    check("mixer", {bias, rtrim, ctrim}, {shadow[1][12:10], shadow[1][8:5], shadow[1][3:0]});
    check("dcnull", {ineg, imag, qneg, qmag}, shadow[3]);
    check("bwmode", bwm, shadow[4][9:8]);
    check("pfd", {cp, edg}, shadow[5][4:0]);
    check("autocal", acd, shadow[8][0]);
    check("band", {bsrc, band_sel}, {shadow[9][7], shadow[9][7] ? shadow[9][6:0] : cal_band});
    check("balun", {balo, bali}, {shadow[0][7:5], shadow[0][3:1]});
    check("bbmode0", bbw, shadow[2]);
    check("bbbias", bbb, shadow[4][11:10]);
    check("abldelay", abl, shadow[5][6:5]);
    check("dither", {den, dmag, dval}, shadow[6][3:0]);
    check("seed", seedw, shadow[7]);
    check("oscset", {seth, setl}, shadow[11][13:0]);
  endtask : chk_ports

  task automatic reset_seq();
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    shadow = rst;
    @(negedge mclk);
    chk_ports();
    for (int k = 0; k < 13; k++) rd(k);
  endtask : reset_seq

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    logic [15:0] r;
    int k;
    reset_seq();
    for (int i = 0; i < 5; i++) begin
      wr(5, {11'h000, i[2:0], i[1:0]});
      wr(4, {6'h00, i[1:0], 8'h00});
      chk_ports();
      rd(5);
    end
    wr(3, 16'h8080);
    chk_ports();
    wr(1, 16'hffff);
    wr(10, 16'hffff);
    wr(12, 16'hffff);
    for (int k2 = 0; k2 < 13; k2++) rd(k2);
    wr(9, 16'h00ab);
    cal_band = 7'h55;
    repeat (4) @(negedge mclk);
    chk_ports();
    rd(10);
    wr(11, `DPR_RST_OSCSET);
    host.frame(1'b0, ofs[1], 16'h0000, 20, 2, r);
    rd(1);
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr_next(rnd);
      k = rnd[3:0] % 13;
      if (k == 11) k = 12;
      wr(k, lfsr_next(rnd));
      cal_band = rnd[6:0];
      repeat (4) @(negedge mclk);
      chk_ports();
      rd(k);
      rd(10);
    end
    reset_seq();
    final_report();
  end
endmodule : tb

bind dpr_regs dpr_regs_properties chk (.mclk(mclk), .sys_rst(sys_rst),
  .serial_cs_n(serial_cs_n), .serial_sdio_oe_n(serial_sdio_oe_n), .cal_band(cal_band),
  .osc_band_sel(osc_band_sel),
  .osc_band_source(osc_band_source), .autocal_disable(autocal_disable), .demod_bias(demod_bias),
  .linearizer_resistor_trim(linearizer_resistor_trim),
  .linearizer_capacitor_trim(linearizer_capacitor_trim),
  .inphase_dc_null_neg(inphase_dc_null_neg), .inphase_dc_null_mag(inphase_dc_null_mag),
  .quadrature_dc_null_neg(quadrature_dc_null_neg), .quadrature_dc_null_mag(quadrature_dc_null_mag),
  .baseband_gain_bw_mode(baseband_gain_bw_mode), .charge_pump_control(charge_pump_control),
  .detector_edge_select(detector_edge_select), .osc_setting_hi(osc_setting_hi),
  .osc_setting_lo(osc_setting_lo));
